// >>> logic/rlc_top.sv
// Top of the four-channel range limit checker with its register file
//
// What this block does
// - Every conversion on each channel is compared with its own limits.
// - An out-of-range result sets that channel's high or low flag.
// - Raw conversions are checked, so averaged outputs hide no bad samples.
// - After reset limits are bipolar positive and negative full scale.
// - Software writes any signed code as a limit; later checks use it.
// - High limits sit at indices 0x32, 0x44, 0x56 and 0x68.
// - Low limits sit at indices 0x35, 0x47, 0x59 and 0x6B.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "rlc_defines.svh"

module rlc_top #(
  parameter int ADDR_W = `RLC_ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire rlc_pkg::rlc_conv_s conv_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq_q
);

  localparam int NUM_CH = `RLC_NUM_CH;
  localparam int CW     = `RLC_CODE_W;
  localparam int IW     = `RLC_IDX_W;
  localparam int IL     = `RLC_IDX_LSB;

  // ****************************************************************
  // Register index tables, channel 0 in the lowest slot
  // ****************************************************************
  localparam logic [NUM_CH-1:0][IW-1:0] HIGH_IDX = {
    `RLC_IDX_CH3_HIGH, `RLC_IDX_CH2_HIGH,
    `RLC_IDX_CH1_HIGH, `RLC_IDX_CH0_HIGH
  };
  localparam logic [NUM_CH-1:0][IW-1:0] LOW_IDX = {
    `RLC_IDX_CH3_LOW, `RLC_IDX_CH2_LOW,
    `RLC_IDX_CH1_LOW, `RLC_IDX_CH0_LOW
  };

  logic                           wr_en;
  logic [ADDR_W-1:0]              wr_addr;
  logic [31:0]                    wr_data;
  logic [3:0]                     wr_strb;
  logic                           wr_err;
  logic [ADDR_W-1:0]              rd_addr;
  logic [31:0]                    rd_data;
  logic                           rd_err;
  logic [IW-1:0]                  wr_idx;
  logic [IW-1:0]                  rd_idx;
  rlc_pkg::rlc_code_t             high_q [NUM_CH];
  rlc_pkg::rlc_code_t             low_q  [NUM_CH];
  rlc_pkg::rlc_hit_s [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0]              high_flags;
  logic [NUM_CH-1:0]              low_flags;
  logic [NUM_CH-1:0]              high_mask_q;
  logic [NUM_CH-1:0]              low_mask_q;
  logic                           clr_high_wr;
  logic                           clr_low_wr;

  assign wr_idx = wr_addr[IL+IW-1:IL];
  assign rd_idx = rd_addr[IL+IW-1:IL];

  // Byte-lane merge of a 20-bit limit; lane 2 carries the top nibble
  function automatic rlc_pkg::rlc_code_t merge_limit(
    input rlc_pkg::rlc_code_t old_v,
    input logic [31:0]        data,
    input logic [3:0]         strb
  );
    rlc_pkg::rlc_code_t v;
    v = old_v;
    if (strb[0])
    begin
      v[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      v[15:8] = data[15:8];
    end
    if (strb[2])
    begin
      v[CW-1:16] = data[CW-1:16];
    end
    return v;
  endfunction

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  rlc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Flag clears are write-one-to-clear on byte lane 0
  assign clr_high_wr = wr_en && wr_strb[0] && (wr_idx == `RLC_IDX_HIGH_FLAGS);
  assign clr_low_wr  = wr_en && wr_strb[0] && (wr_idx == `RLC_IDX_LOW_FLAGS);

  // ****************************************************************
  // Per-channel limit registers and checkers
  // ****************************************************************
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic hi_sel;
      logic lo_sel;

      assign hi_sel = wr_en && (wr_idx == HIGH_IDX[ch]);
      assign lo_sel = wr_en && (wr_idx == LOW_IDX[ch]);

      // Limits: bipolar full scale out of reset, then whatever is written
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          high_q[ch] <= `RLC_HIGH_RESET;
          low_q[ch]  <= `RLC_LOW_RESET;
        end
        else
        begin
          if (hi_sel)
          begin
            high_q[ch] <= merge_limit(high_q[ch], wr_data, wr_strb);
          end
          if (lo_sel)
          begin
            low_q[ch] <= merge_limit(low_q[ch], wr_data, wr_strb);
          end
        end
      end

      // Fed by every raw conversion, never by the averaged result
      rlc_limit_cmp u_cmp (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .conv_valid (conv_in.valid[ch]),
        .conv_code  (conv_in.code[ch]),
        .high_limit (high_q[ch]),
        .low_limit  (low_q[ch]),
        .clr_high   (clr_high_wr && wr_data[ch]),
        .clr_low    (clr_low_wr && wr_data[ch]),
        .hit_q      (hit[ch])
      );

      assign high_flags[ch] = hit[ch].hit_high;
      assign low_flags[ch]  = hit[ch].hit_low;
    end
  endgenerate

  // ****************************************************************
  // Interrupt masks and output
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      high_mask_q <= `RLC_MASK_RESET;
      low_mask_q  <= `RLC_MASK_RESET;
    end
    else if (wr_en && wr_strb[0])
    begin
      if (wr_idx == `RLC_IDX_HIGH_MASK)
      begin
        high_mask_q <= wr_data[NUM_CH-1:0];
      end
      if (wr_idx == `RLC_IDX_LOW_MASK)
      begin
        low_mask_q <= wr_data[NUM_CH-1:0];
      end
    end
  end

  // Registered, so the line rises one cycle after the flag is seen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |((high_flags & high_mask_q) | (low_flags & low_mask_q));
    end
  end

  // ****************************************************************
  // Address decode for writes and read data mux
  // ****************************************************************
  always_comb
  begin
    wr_err = 1'b1;
    if ((wr_idx == `RLC_IDX_HIGH_FLAGS) || (wr_idx == `RLC_IDX_LOW_FLAGS) ||
        (wr_idx == `RLC_IDX_HIGH_MASK) || (wr_idx == `RLC_IDX_LOW_MASK))
    begin
      wr_err = 1'b0;
    end
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      if ((wr_idx == HIGH_IDX[ch]) || (wr_idx == LOW_IDX[ch]))
      begin
        wr_err = 1'b0;
      end
    end
  end

  // Limits read back sign-extended to 24 bits; bits above read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b1;
    unique case (rd_idx)
      `RLC_IDX_HIGH_FLAGS:
      begin
        rd_data[NUM_CH-1:0] = high_flags;
        rd_err              = 1'b0;
      end
      `RLC_IDX_LOW_FLAGS:
      begin
        rd_data[NUM_CH-1:0] = low_flags;
        rd_err              = 1'b0;
      end
      `RLC_IDX_HIGH_MASK:
      begin
        rd_data[NUM_CH-1:0] = high_mask_q;
        rd_err              = 1'b0;
      end
      `RLC_IDX_LOW_MASK:
      begin
        rd_data[NUM_CH-1:0] = low_mask_q;
        rd_err              = 1'b0;
      end
      default:
      begin
        rd_err = 1'b1;
      end
    endcase
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      if (rd_idx == HIGH_IDX[ch])
      begin
        rd_data[`RLC_LIM_READ_W-1:0] =
          {{(`RLC_LIM_READ_W-CW){high_q[ch][`RLC_SIGN_BIT]}}, high_q[ch]};
        rd_err = 1'b0;
      end
      if (rd_idx == LOW_IDX[ch])
      begin
        rd_data[`RLC_LIM_READ_W-1:0] =
          {{(`RLC_LIM_READ_W-CW){low_q[ch][`RLC_SIGN_BIT]}}, low_q[ch]};
        rd_err = 1'b0;
      end
    end
  end

endmodule

// >>> shared/rlc_defines.svh
// Constants for the channel range limit checker: sizes, indices, resets
`ifndef RLC_DEFINES_SVH
`define RLC_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define RLC_NUM_CH        4
`define RLC_CODE_W        20
`define RLC_ADDR_W        9
`define RLC_IDX_W         7
`define RLC_IDX_LSB       2

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define RLC_IDX_CH0_HIGH  7'h32
`define RLC_IDX_CH0_LOW   7'h35
`define RLC_IDX_CH1_HIGH  7'h44
`define RLC_IDX_CH1_LOW   7'h47
`define RLC_IDX_CH2_HIGH  7'h56
`define RLC_IDX_CH2_LOW   7'h59
`define RLC_IDX_CH3_HIGH  7'h68
`define RLC_IDX_CH3_LOW   7'h6B
`define RLC_IDX_HIGH_FLAGS 7'h70
`define RLC_IDX_LOW_FLAGS  7'h71
`define RLC_IDX_HIGH_MASK  7'h72
`define RLC_IDX_LOW_MASK   7'h73

// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define RLC_HIGH_RESET    20'h7FFFF
`define RLC_LOW_RESET     20'h80000
`define RLC_MASK_RESET    4'h0
`define RLC_SIGN_BIT      19
`define RLC_LIM_READ_W    24

// ****************************************************************
// AXI4-Lite answer codes
// ****************************************************************
`define RLC_RESP_OKAY     2'h0
`define RLC_RESP_SLVERR   2'h2

`endif

// >>> shared/rlc_pkg.sv
// Types shared by the channel range limit checker files
`include "rlc_defines.svh"

package rlc_pkg;

  // ****************************************************************
  // Conversion stream and limit types
  // ****************************************************************
  typedef logic signed [`RLC_CODE_W-1:0] rlc_code_t;

  // One raw conversion per channel, before any averaging
  typedef struct packed {
    logic [`RLC_NUM_CH-1:0]                  valid;
    logic [`RLC_NUM_CH-1:0][`RLC_CODE_W-1:0] code;
  } rlc_conv_s;

  // Flag pair reported by each channel checker
  typedef struct packed {
    logic hit_high;
    logic hit_low;
  } rlc_hit_s;

endpackage

// >>> logic/rlc_axil_slave.sv
// AXI4-Lite slave front end for the range limit checker registers
`timescale 1ns/1ns
`include "rlc_defines.svh"

module rlc_axil_slave #(
  parameter int ADDR_W = `RLC_ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);

  logic aw_held_q;
  logic w_held_q;

  // Write commits only once address and data are both held and the
  // previous answer has gone, so one write is in flight at a time
  assign wr_en   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_addr = s_axi_araddr;

  // ****************************************************************
  // Write address channel
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      wr_addr       <= '0;
    end
    else if (wr_en)
    begin
      aw_held_q     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q     <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_addr       <= s_axi_awaddr;
    end
    else
    begin
      s_axi_awready <= !aw_held_q;
    end
  end

  // ****************************************************************
  // Write data channel
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q     <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_data      <= '0;
      wr_strb      <= '0;
    end
    else if (wr_en)
    begin
      w_held_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q     <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data      <= s_axi_wdata;
      wr_strb      <= s_axi_wstrb;
    end
    else
    begin
      s_axi_wready <= !w_held_q;
    end
  end

  // ****************************************************************
  // Write response
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RLC_RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? `RLC_RESP_SLVERR : `RLC_RESP_OKAY;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Read channel; data is sampled at the address handshake
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RLC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_err ? 32'h0000_0000 : rd_data;
      s_axi_rresp   <= rd_err ? `RLC_RESP_SLVERR : `RLC_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

endmodule

// >>> logic/rlc_limit_cmp.sv
// One channel's limit comparison with its sticky high and low flags
`timescale 1ns/1ns
`include "rlc_defines.svh"

module rlc_limit_cmp (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              conv_valid,
  input  wire rlc_pkg::rlc_code_t conv_code,
  input  wire rlc_pkg::rlc_code_t high_limit,
  input  wire rlc_pkg::rlc_code_t low_limit,
  input  wire logic              clr_high,
  input  wire logic              clr_low,
  output rlc_pkg::rlc_hit_s      hit_q
);

  logic above;
  logic below;

  // Signed compares, strict on both sides so a code equal to a limit
  // is still in range
  assign above = conv_valid && (conv_code > high_limit);
  assign below = conv_valid && (conv_code < low_limit);

  // ****************************************************************
  // Sticky flags; a new hit in the clearing cycle keeps the flag set
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hit_q <= '0;
    end
    else
    begin
      hit_q.hit_high <= (hit_q.hit_high && !clr_high) || above;
      hit_q.hit_low  <= (hit_q.hit_low && !clr_low) || below;
    end
  end

endmodule

// >>> sim/rlc_host.sv
// Bus master model of the digital host that sets limits and reads flags
`timescale 1ns/1ns

module rlc_host (
  input  wire logic        aclk,
  output logic [8:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [8:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic        slow = 1'b0;
  logic        done = 1'b0;
  logic [1:0]  resp;
  logic [31:0] rd_q;

  // Quiet bus at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Each channel lets go at the edge that takes it
  always @(posedge aclk)
  begin
    if (awvalid && awready)
      awvalid <= 1'b0;
    if (wvalid && wready)
      wvalid <= 1'b0;
    if (arvalid && arready)
      arvalid <= 1'b0;
    if (bready && bvalid)
      bready <= 1'b0;
    if (rready && rvalid)
      rready <= 1'b0;
    if ((bready && bvalid) || (rready && rvalid))
    begin
      done <= 1'b1;
      resp <= bvalid ? bresp : rresp;
      rd_q <= rdata;
    end
  end

  // One transfer; a slow host holds off its answer ready for three cycles
  task automatic xfer(input logic wr, input logic [8:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic [1:0] r);
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, d};
    awvalid <= wr;
    wvalid  <= wr;
    arvalid <= !wr;
    bready  <= wr && !slow;
    rready  <= !wr && !slow;
    done    <= 1'b0;
    if (slow)
    begin
      repeat (3) @(posedge aclk);
      bready <= wr;
      rready <= !wr;
    end
    do @(negedge aclk); while (!done);
    q = rd_q;
    r = resp;
  endtask
endmodule

// >>> sim/rlc_assertions.sv
// Port checker of the range limit checker top, bound into every instance
`timescale 1ns/1ns

module rlc_assertions (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire rlc_pkg::rlc_conv_s conv_in,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               irq_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Register bus answers come on time and stand until taken
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");

  // Limits read back as 20-bit signed codes, sign extended to bit 23
  a_read_pad: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
    else $error("read top byte set");
  a_read_sign: assert property (
    s_axi_rvalid && (s_axi_rdata[23:20] != 4'h0)
    |-> s_axi_rdata[23:19] == 5'h1F) else $error("bad sign extension");

  // Interrupt only rises after a conversion or a register write, and only
  // a write can clear it, since flags stay until software clears them
  a_irq_rise: assert property (
    $rose(irq_q) |-> $past(|conv_in.valid, 2) || $past(s_axi_bvalid))
    else $error("interrupt without cause");
  a_irq_fall: assert property (
    $fell(irq_q) |-> $past(s_axi_bvalid)) else $error("flag lost");
endmodule

bind rlc_top rlc_assertions u_chk (.*);

// >>> sim/tb.sv
// Self-checking bench of the four-channel range limit checker
`timescale 1ns/1ns
`include "rlc_defines.svh"

module tb;
  localparam int         LIMIT = 30000;
  localparam logic [1:0] OK    = `RLC_RESP_OKAY;
  localparam logic [1:0] ERR   = `RLC_RESP_SLVERR;
  logic               aclk;
  logic               aresetn;
  rlc_pkg::rlc_conv_s conv;
  logic [8:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [1:0]         bresp, rresp;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready, irq;
  int                 errors = 0;
  int                 checks_done = 0;
  int                 cycles = 0;
  logic [19:0]        hi [4];
  logic [19:0]        lo [4];
  logic [6:0]         hi_idx [4] = '{`RLC_IDX_CH0_HIGH, `RLC_IDX_CH1_HIGH,
                                     `RLC_IDX_CH2_HIGH, `RLC_IDX_CH3_HIGH};
  logic [6:0]         lo_idx [4] = '{`RLC_IDX_CH0_LOW, `RLC_IDX_CH1_LOW,
                                     `RLC_IDX_CH2_LOW, `RLC_IDX_CH3_LOW};

  rlc_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .conv_in(conv),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_q(irq)
  );

  rlc_host u_host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready)
  );

  // Free running 125 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Hang guard: a run far beyond the expected length is a failure
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected read of a limit: 20-bit code sign extended to bit 23
  function automatic logic [31:0] ext(input logic [19:0] v);
    return {8'h00, {4{v[19]}}, v};
  endfunction

  // Register access by index; the byte address is four times the index
  task automatic rdchk(input logic [6:0] idx, input logic [31:0] exp,
                       input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    u_host.xfer(1'b0, {idx, 2'b00}, 32'h0, q, r);
    chk(q, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic wrreg(input logic [6:0] idx, input logic [31:0] d,
                       input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    u_host.xfer(1'b1, {idx, 2'b00}, d, q, r);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // One raw conversion on one channel, a single-cycle strobe
  task automatic conv1(input int ch, input logic [19:0] c);
    @(posedge aclk);
    conv.valid[ch] <= 1'b1;
    conv.code[ch]  <= c;
    @(posedge aclk);
    conv.valid <= 4'h0;
  endtask

  task automatic flags(input logic [3:0] eh, input logic [3:0] el);
    rdchk(`RLC_IDX_HIGH_FLAGS, {28'h0, eh}, OK);
    rdchk(`RLC_IDX_LOW_FLAGS, {28'h0, el}, OK);
  endtask

  task automatic clr();
    wrreg(`RLC_IDX_HIGH_FLAGS, 32'hF, OK);
    wrreg(`RLC_IDX_LOW_FLAGS, 32'hF, OK);
    flags(4'h0, 4'h0);
  endtask

  // Full scale defaults never trip; a hole in the map is refused
  task automatic t_defaults();
    for (int ch = 0; ch < 4; ch++)
    begin
      rdchk(hi_idx[ch], ext(`RLC_HIGH_RESET), OK);
      rdchk(lo_idx[ch], ext(`RLC_LOW_RESET), OK);
      conv1(ch, `RLC_HIGH_RESET);
      conv1(ch, `RLC_LOW_RESET);
    end
    flags(4'h0, 4'h0);
    rdchk(`RLC_IDX_HIGH_MASK, 32'h0, OK);
    rdchk(`RLC_IDX_LOW_MASK, 32'h0, OK);
    wrreg(7'h33, 32'hFFFF_FFFF, ERR);
    rdchk(7'h33, 32'h0, ERR);
    rdchk(`RLC_IDX_CH0_HIGH, ext(`RLC_HIGH_RESET), OK);
    $display("test defaults done");
  endtask

  // Written limits, junk in the upper bits, equal codes stay in range
  task automatic t_limits();
    for (int ch = 0; ch < 4; ch++)
    begin
      hi[ch] = 20'h00400 << ch;
      lo[ch] = ~hi[ch];
      wrreg(hi_idx[ch], {12'hABC, hi[ch]}, OK);
      wrreg(lo_idx[ch], {12'h5A5, lo[ch]}, OK);
      rdchk(hi_idx[ch], ext(hi[ch]), OK);
      rdchk(lo_idx[ch], ext(lo[ch]), OK);
    end
    for (int ch = 0; ch < 4; ch++)
    begin
      conv1(ch, hi[ch]);
      conv1(ch, lo[ch]);
      flags(4'h0, 4'h0);
      conv1(ch, hi[ch] + 20'h1);
      flags(4'h1 << ch, 4'h0);
      conv1(ch, lo[ch] - 20'h1);
      flags(4'h1 << ch, 4'h1 << ch);
      clr();
    end
    $display("test limits done");
  endtask

  // Back to back samples on all channels, one bad sample mid burst
  task automatic t_burst();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge aclk);
      conv.valid <= 4'hF;
      for (int k = 0; k < 4; k++)
        conv.code[k] <= (i == 5 && k == 2) ? hi[2] + 20'h1 : 20'h00000;
    end
    @(posedge aclk);
    conv.valid <= 4'h0;
    flags(4'h4, 4'h0);
    conv1(2, 20'h00000);
    flags(4'h4, 4'h0);
    clr();
    $display("test burst done");
  endtask

  task automatic irqchk(input logic e);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // Interrupt follows masked flags; the host answers slowly here
  task automatic t_irq();
    u_host.slow = 1'b1;
    wrreg(`RLC_IDX_HIGH_MASK, 32'h1, OK);
    conv1(1, hi[1] + 20'h1);
    irqchk(1'b0);
    conv1(0, hi[0] + 20'h1);
    irqchk(1'b1);
    wrreg(`RLC_IDX_HIGH_MASK, 32'h0, OK);
    irqchk(1'b0);
    wrreg(`RLC_IDX_LOW_MASK, 32'h8, OK);
    conv1(3, lo[3] - 20'h1);
    irqchk(1'b1);
    wrreg(`RLC_IDX_LOW_FLAGS, 32'h8, OK);
    irqchk(1'b0);
    flags(4'h3, 4'h0);
    clr();
    u_host.slow = 1'b0;
    $display("test irq done");
  endtask

  // Reset held for twelve cycles, then the scenarios in turn
  initial
  begin
    aresetn = 1'b0;
    conv = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_limits();
    t_burst();
    t_irq();
    summarize();
  end
endmodule
